/* hw/fac_consts.svh */
// Register offsets, reset values, field positions and bus constants of the fan alarm bank.
`ifndef FAC_CONSTS_SVH
`define FAC_CONSTS_SVH

// ********************************************************************
// Register offsets
// ********************************************************************
`define FAC_OFF_CTRL3 8'h02
`define FAC_OFF_FAN_FAULT_DUTY 8'h03
`define FAC_OFF_MASK 8'h04
`define FAC_OFF_IDEAL 8'h05
`define FAC_OFF_RH_UP 8'h06
`define FAC_OFF_RH_LO 8'h07
`define FAC_OFF_LOT_UP 8'h08
`define FAC_OFF_LOT_LO 8'h09

// ********************************************************************
// Reset values
// ********************************************************************
`define FAC_RST_CTRL3 7'h03
`define FAC_RST_FAN_FAULT_DUTY 8'hff
`define FAC_RST_MASK 8'hc0
`define FAC_RST_IDEAL 8'h18
`define FAC_RST_LIM_UP 8'h55
`define FAC_RST_LIM_LO 3'h0

// ********************************************************************
// Field positions
// ********************************************************************
`define FAC_CLEAR_FAN_FAIL_BIT 7
`define FAC_STRETCH_BIT 2
`define FAC_MON_MSB 1
`define FAC_CTRL3_MSB 6
`define FAC_LOCAL_HIGH_ALARM_MASK_BIT 5
`define FAC_LOCAL_OVERTEMP_ALARM_MASK_BIT 4
`define FAC_REMOTE_HIGH_ALARM_MASK_BIT 3
`define FAC_REMOTE_OVERTEMP_ALARM_MASK_BIT 2
`define FAC_IDEAL_MSB 5
`define FAC_LIM_LO_MSB 7
`define FAC_LIM_LO_LSB 5
`define FAC_LIM_PAD 5'h00
`define FAC_NUM_TACH 2

// ********************************************************************
// Power-up load range and serial bus
// ********************************************************************
`define FAC_NV_FIRST 8'h02
`define FAC_NV_LAST 8'h09
`define FAC_I2C_ADDR 7'h50
`define FAC_BIT_LAST 4'h7
`define FAC_BIT_ACK 4'h8
`define FAC_BIT_ZERO 4'h0
`define FAC_PTR_STEP 8'h01

`endif

/* hw/fac_pkg.sv */
// Types shared by the fan alarm register bank modules.
package fac_pkg;
  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_ADDR,
    I2C_PTR,
    I2C_WR,
    I2C_RD
  } fac_i2c_state_t;

  typedef enum logic [1:0] {
    LOAD_ADDR,
    LOAD_DATA,
    LOAD_DONE
  } fac_load_state_t;
endpackage

/* hw/fac_reg_if.sv */
// Register write and read carrier between the bank and its access agents.
`timescale 1ns/1ps
interface fac_reg_if;
  logic wrEn;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport master (output wrEn, output addr, output wdata, input rdata);
  modport slave (input wrEn, input addr, input wdata, output rdata);
endinterface

/* hw/fac_nv_loader.sv */
// Power-up copier from the nonvolatile store into the register bank.
`timescale 1ns/1ps
`include "fac_consts.svh"
module fac_nv_loader
  import fac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] nvData,
  output logic [7:0] nvAddr,
  output logic loadDone,
  fac_reg_if.master bus
);
  fac_load_state_t state_q;
  logic [7:0] idx_q;

  // One read cycle of latency: address in LOAD_ADDR, data taken in LOAD_DATA.
  assign nvAddr = idx_q;
  assign bus.wrEn = (state_q == LOAD_DATA);
  assign bus.addr = idx_q;
  assign bus.wdata = nvData;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= LOAD_ADDR;
      idx_q <= `FAC_NV_FIRST;
      loadDone <= 1'b0;
    end else begin
      case (state_q)
        LOAD_ADDR: begin
          state_q <= LOAD_DATA;
        end
        LOAD_DATA: begin
          if (idx_q == `FAC_NV_LAST) begin
            state_q <= LOAD_DONE;
            loadDone <= 1'b1;
          end else begin
            idx_q <= idx_q + `FAC_PTR_STEP;
            state_q <= LOAD_ADDR;
          end
        end
        LOAD_DONE: begin
          loadDone <= 1'b1;
        end
        default: begin
          state_q <= LOAD_ADDR;
        end
      endcase
    end
  end
endmodule

/* hw/fac_i2c_slave.sv */
// Two-wire serial bus slave with a register pointer and auto-increment.
`timescale 1ns/1ps
`include "fac_consts.svh"
module fac_i2c_slave
  import fac_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `FAC_I2C_ADDR
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOe,
  fac_reg_if.master bus
);
  fac_i2c_state_t state_q;
  logic [1:0] sclSync_q;
  logic [1:0] sdaSync_q;
  logic sclPrev_q;
  logic sdaPrev_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic rdNack_q;
  logic skipFall_q;

  wire sclS = sclSync_q[1];
  wire sdaS = sdaSync_q[1];
  wire startSeen = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
  wire stopSeen = sclS & sclPrev_q & ~sdaPrev_q & sdaS;
  wire sclRise = sclS & ~sclPrev_q;
  wire sclFall = ~sclS & sclPrev_q;
  wire addrHit = (shift_q[7:1] == DEV_ADDR);
  wire byteEnd = sclFall & (bitCnt_q == `FAC_BIT_LAST);

  assign bus.wrEn = byteEnd & (state_q == I2C_WR);
  assign bus.addr = ptr_q;
  assign bus.wdata = shift_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclSync_q <= {sclSync_q[0], sclIn};
      sdaSync_q <= {sdaSync_q[0], sdaIn};
      sclPrev_q <= sclS;
      sdaPrev_q <= sdaS;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= I2C_IDLE;
      bitCnt_q <= `FAC_BIT_ZERO;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      rdNack_q <= 1'b0;
      skipFall_q <= 1'b0;
      sdaOe <= 1'b0;
    end else if (startSeen) begin
      state_q <= I2C_ADDR;
      skipFall_q <= 1'b1;
      bitCnt_q <= `FAC_BIT_ZERO;
      sdaOe <= 1'b0;
    end else if (stopSeen) begin
      state_q <= I2C_IDLE;
      sdaOe <= 1'b0;
    end else if (state_q != I2C_IDLE) begin
      if (sclRise) begin
        if (bitCnt_q == `FAC_BIT_ACK) begin
          rdNack_q <= sdaS;
        end else if (state_q != I2C_RD) begin
          shift_q <= {shift_q[6:0], sdaS};
        end
      end
      // The clock fall that closes a start condition is not a data bit.
      if (sclFall && skipFall_q) begin
        skipFall_q <= 1'b0;
      end else if (sclFall) begin
        if (bitCnt_q < `FAC_BIT_LAST) begin
          bitCnt_q <= bitCnt_q + 4'h1;
          if (state_q == I2C_RD) begin
            sdaOe <= ~shift_q[6];
            shift_q <= {shift_q[6:0], 1'b0};
          end
        end else if (bitCnt_q == `FAC_BIT_LAST) begin
          bitCnt_q <= `FAC_BIT_ACK;
          case (state_q)
            I2C_ADDR: sdaOe <= addrHit;
            I2C_PTR: begin
              ptr_q <= shift_q;
              sdaOe <= 1'b1;
            end
            I2C_WR: begin
              ptr_q <= ptr_q + `FAC_PTR_STEP;
              sdaOe <= 1'b1;
            end
            default: sdaOe <= 1'b0;
          endcase
        end else begin
          bitCnt_q <= `FAC_BIT_ZERO;
          sdaOe <= 1'b0;
          case (state_q)
            I2C_ADDR: begin
              if (!addrHit) begin
                state_q <= I2C_IDLE;
              end else if (shift_q[0]) begin
                state_q <= I2C_RD;
                shift_q <= bus.rdata;
                sdaOe <= ~bus.rdata[7];
                ptr_q <= ptr_q + `FAC_PTR_STEP;
              end else begin
                state_q <= I2C_PTR;
              end
            end
            I2C_PTR: state_q <= I2C_WR;
            I2C_WR: state_q <= I2C_WR;
            I2C_RD: begin
              if (rdNack_q) begin
                state_q <= I2C_IDLE;
              end else begin
                shift_q <= bus.rdata;
                sdaOe <= ~bus.rdata[7];
                ptr_q <= ptr_q + `FAC_PTR_STEP;
              end
            end
            default: state_q <= I2C_IDLE;
          endcase
        end
      end
    end
  end
endmodule

/* hw/fac_alarm_regs.sv */
// Fan alarm configuration register bank with alarm routing and fault duty control.
`timescale 1ns/1ps
`include "fac_consts.svh"

module fac_alarm_regs
  import fac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [7:0] nvData,
  output logic [7:0] nvAddr,
  output logic loadDone,
  input wire logic [15:0] localTemp,
  input wire logic [15:0] remoteTemp,
  input wire logic localHighAlarm,
  input wire logic remoteOvertempAlarm,
  input wire logic pwmLowestFreq,
  input wire logic failInterruptMode,
  input wire logic firstSpeedAlarmEvent,
  input wire logic secondSpeedAlarmEvent,
  output logic stretchActive,
  output logic firstSpeedMonitorEnable,
  output logic secondSpeedMonitorEnable,
  output logic [1:0] fanFailStatus,
  output logic faultDutyActive,
  output logic [7:0] faultDuty,
  output logic [5:0] idealityCode,
  output logic alertOut_n,
  output logic shutdownOut_n,
  output logic failOut_n
);
  // ********************************************************************
  // Access agents
  // ********************************************************************
  fac_reg_if hostIf ();
  fac_reg_if nvIf ();

  fac_i2c_slave u_i2c (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaOe(sdaOe),
    .bus(hostIf.master)
  );

  fac_nv_loader u_loader (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .nvData(nvData),
    .nvAddr(nvAddr),
    .loadDone(loadDone),
    .bus(nvIf.master)
  );

  function automatic logic regHit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ********************************************************************
  // Write selection
  // ********************************************************************
  // Host writes are ignored until the power-up copy is complete.
  wire wrEn = loadDone ? hostIf.wrEn : nvIf.wrEn;
  wire [7:0] wrAddr = loadDone ? hostIf.addr : nvIf.addr;
  wire [7:0] wrData = loadDone ? hostIf.wdata : nvIf.wdata;
  assign nvIf.rdata = 8'h00;

  logic [6:0] ctrl3_q;
  logic [7:0] fan_fault_duty_q;
  logic [7:0] mask_q;
  logic [7:0] ideal_q;
  logic [7:0] rhUp_q;
  logic [2:0] rhLo_q;
  logic [7:0] lotUp_q;
  logic [2:0] lotLo_q;
  logic sdaLow_q;

  wire wrCtrl3 = wrEn & regHit(wrAddr, `FAC_OFF_CTRL3);
  wire wrFfdc = wrEn & regHit(wrAddr, `FAC_OFF_FAN_FAULT_DUTY);
  wire wrMask = wrEn & regHit(wrAddr, `FAC_OFF_MASK);
  wire wrIdeal = wrEn & regHit(wrAddr, `FAC_OFF_IDEAL);
  wire wrRhUp = wrEn & regHit(wrAddr, `FAC_OFF_RH_UP);
  wire wrRhLo = wrEn & regHit(wrAddr, `FAC_OFF_RH_LO);
  wire wrLotUp = wrEn & regHit(wrAddr, `FAC_OFF_LOT_UP);
  wire wrLotLo = wrEn & regHit(wrAddr, `FAC_OFF_LOT_LO);
  // Clear-fail is a pulse only; it is never stored, so it reads back as zero.
  wire clearFanFail = wrCtrl3 & wrData[`FAC_CLEAR_FAN_FAIL_BIT] & loadDone;

  // ********************************************************************
  // Register storage
  // ********************************************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl3_q <= `FAC_RST_CTRL3;
    end else if (wrCtrl3) begin
      ctrl3_q <= wrData[`FAC_CTRL3_MSB:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fan_fault_duty_q <= `FAC_RST_FAN_FAULT_DUTY;
    end else if (wrFfdc) begin
      fan_fault_duty_q <= wrData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mask_q <= `FAC_RST_MASK;
    end else if (wrMask) begin
      mask_q <= wrData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ideal_q <= `FAC_RST_IDEAL;
    end else if (wrIdeal) begin
      ideal_q <= wrData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rhUp_q <= `FAC_RST_LIM_UP;
    end else if (wrRhUp) begin
      rhUp_q <= wrData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rhLo_q <= `FAC_RST_LIM_LO;
    end else if (wrRhLo) begin
      rhLo_q <= wrData[`FAC_LIM_LO_MSB:`FAC_LIM_LO_LSB];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lotUp_q <= `FAC_RST_LIM_UP;
    end else if (wrLotUp) begin
      lotUp_q <= wrData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lotLo_q <= `FAC_RST_LIM_LO;
    end else if (wrLotLo) begin
      lotLo_q <= wrData[`FAC_LIM_LO_MSB:`FAC_LIM_LO_LSB];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sdaLow_q <= 1'b0;
    end else begin
      sdaLow_q <= 1'b0;
    end
  end

  // ********************************************************************
  // Read back
  // ********************************************************************
  wire [7:0] rdSel = hostIf.addr;
  assign hostIf.rdata =
    regHit(rdSel, `FAC_OFF_CTRL3) ? {1'b0, ctrl3_q} :
    regHit(rdSel, `FAC_OFF_FAN_FAULT_DUTY) ? fan_fault_duty_q :
    regHit(rdSel, `FAC_OFF_MASK) ? mask_q :
    regHit(rdSel, `FAC_OFF_IDEAL) ? ideal_q :
    regHit(rdSel, `FAC_OFF_RH_UP) ? rhUp_q :
    regHit(rdSel, `FAC_OFF_RH_LO) ? {rhLo_q, `FAC_LIM_PAD} :
    regHit(rdSel, `FAC_OFF_LOT_UP) ? lotUp_q :
    regHit(rdSel, `FAC_OFF_LOT_LO) ? {lotLo_q, `FAC_LIM_PAD} :
    8'h00;

  // ********************************************************************
  // Temperature comparisons
  // ********************************************************************
  wire signed [15:0] rhLimit = {rhUp_q, rhLo_q, `FAC_LIM_PAD};
  wire signed [15:0] lotLimit = {lotUp_q, lotLo_q, `FAC_LIM_PAD};
  wire remoteHighAlarm = $signed(remoteTemp) > rhLimit;
  wire localOvertempAlarm = $signed(localTemp) > lotLimit;

  wire alertNext = (localHighAlarm & ~mask_q[`FAC_LOCAL_HIGH_ALARM_MASK_BIT]) |
    (remoteHighAlarm & ~mask_q[`FAC_REMOTE_HIGH_ALARM_MASK_BIT]);
  wire shutdownNext = (localOvertempAlarm & ~mask_q[`FAC_LOCAL_OVERTEMP_ALARM_MASK_BIT]) |
    (remoteOvertempAlarm & ~mask_q[`FAC_REMOTE_OVERTEMP_ALARM_MASK_BIT]);

  // ********************************************************************
  // Tach fail status
  // ********************************************************************
  wire [1:0] speedEvent = {secondSpeedAlarmEvent, firstSpeedAlarmEvent};
  wire [1:0] monEnable = ctrl3_q[`FAC_MON_MSB:0];
  logic [1:0] failStatus_q;
  logic [1:0] failStatus_d;
  logic [1:0] failRouteLatched;
  logic [1:0] failRouteLive;

  genvar gi;
  generate
    for (gi = 0; gi < `FAC_NUM_TACH; gi++) begin : g_tach
      // Disable wins outright; otherwise a new event wins over clear-fail.
      assign failStatus_d[gi] = monEnable[gi] &
        (speedEvent[gi] | (failStatus_q[gi] & ~clearFanFail));
      assign failRouteLatched[gi] = failStatus_q[gi] & ~mask_q[gi];
      assign failRouteLive[gi] = speedEvent[gi] & monEnable[gi] & ~mask_q[gi];
    end
  endgenerate

  // Interrupt mode holds the output from status; comparator mode follows the event.
  wire failNext = failInterruptMode ? (|failRouteLatched) : (|failRouteLive);
  wire stretchNext = ctrl3_q[`FAC_STRETCH_BIT] & pwmLowestFreq;

  // ********************************************************************
  // Output registers
  // ********************************************************************
  // Every route is held inactive until the nonvolatile copy has landed.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      failStatus_q <= 2'h0;
      faultDutyActive <= 1'b0;
    end else begin
      failStatus_q <= loadDone ? failStatus_d : 2'h0;
      faultDutyActive <= (|failStatus_d) & loadDone;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stretchActive <= 1'b0;
    end else begin
      stretchActive <= stretchNext & loadDone;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      firstSpeedMonitorEnable <= 1'b0;
      secondSpeedMonitorEnable <= 1'b0;
    end else begin
      firstSpeedMonitorEnable <= monEnable[0] & loadDone;
      secondSpeedMonitorEnable <= monEnable[1] & loadDone;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      faultDuty <= `FAC_RST_FAN_FAULT_DUTY;
      idealityCode <= 6'(`FAC_RST_IDEAL);
    end else begin
      faultDuty <= fan_fault_duty_q;
      idealityCode <= ideal_q[`FAC_IDEAL_MSB:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      alertOut_n <= 1'b1;
      shutdownOut_n <= 1'b1;
    end else begin
      alertOut_n <= ~(alertNext & loadDone);
      shutdownOut_n <= ~(shutdownNext & loadDone);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      failOut_n <= 1'b1;
    end else begin
      failOut_n <= ~(failNext & loadDone);
    end
  end

  assign fanFailStatus = failStatus_q;
  assign sdaOut = sdaLow_q;
endmodule

/* testbench/fac_i2c_host.sv */
// Two-wire bus host model that drives clock and data toward the bank.
`timescale 1ns/1ps
module fac_i2c_host (
  input wire logic ref_clk,
  input wire logic sdaOe,
  output logic scl,
  output logic sda
);
  logic sdaDrv = 1'b1;
  int halfCyc = 6;
  // The data line has a pull-up, so a released line reads one.
  assign sda = sdaDrv & ~sdaOe;
  initial scl = 1'b1;
  task automatic tick();
    repeat (halfCyc) @(posedge ref_clk);
    #1;
  endtask
  // Data only moves while the clock is low, except in start and stop framing.
  task automatic clockBit(input logic b, output logic s);
    tick();
    sdaDrv = b;
    tick();
    scl = 1'b1;
    tick();
    s = sda;
    scl = 1'b0;
  endtask
  task automatic frame(input logic first, input logic second);
    tick();
    sdaDrv = first;
    tick();
    scl = 1'b1;
    tick();
    sdaDrv = second;
    tick();
  endtask
  task automatic start();
    frame(1'b1, 1'b0);
    scl = 1'b0;
  endtask
  task automatic stop();
    frame(1'b0, 1'b1);
  endtask
  task automatic xferByte(input logic [7:0] tx, input logic ackBit, output logic [8:0] rx);
    logic [8:0] f;
    f = {tx, ackBit};
    for (int i = 8; i >= 0; i--) clockBit(f[i], rx[i]);
  endtask
endmodule

/* testbench/fac_alarm_regs_monitor.sv */
// Port-level assertions for the fan alarm register bank.
`timescale 1ns/1ps
module fac_alarm_regs_monitor (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic loadDone,
  input wire logic [15:0] localTemp,
  input wire logic [15:0] remoteTemp,
  input wire logic localHighAlarm,
  input wire logic remoteOvertempAlarm,
  input wire logic pwmLowestFreq,
  input wire logic failInterruptMode,
  input wire logic firstSpeedAlarmEvent,
  input wire logic secondSpeedAlarmEvent,
  input wire logic stretchActive,
  input wire logic firstSpeedMonitorEnable,
  input wire logic secondSpeedMonitorEnable,
  input wire logic [1:0] fanFailStatus,
  input wire logic faultDutyActive,
  input wire logic [7:0] faultDuty,
  input wire logic [5:0] idealityCode,
  input wire logic alertOut_n,
  input wire logic shutdownOut_n,
  input wire logic failOut_n
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  a_stretch_gate: assert property (stretchActive |-> $past(pwmLowestFreq) && loadDone)
    else $error("stretch without lowest rate");
  a_second_off: assert property (!secondSpeedMonitorEnable |-> !fanFailStatus[1])
    else $error("second status while off");
  a_first_off: assert property (!firstSpeedMonitorEnable |-> !fanFailStatus[0])
    else $error("first status while off");
  a_duty_follow: assert property (faultDutyActive == (|fanFailStatus))
    else $error("fault duty select wrong");
  a_reset_dflt: assert property ($past(sys_rst) |-> faultDuty == 8'hff && idealityCode == 6'h18)
    else $error("reset copies wrong");
  a_alert_cause: assert property (!alertOut_n |-> $past(localHighAlarm) || $past(remoteTemp) != 16'h8000)
    else $error("alert without cause");
  a_shutdown_out_cause: assert property (!shutdownOut_n |-> $past(remoteOvertempAlarm) || $past(localTemp) != 16'h8000)
    else $error("shutdown without cause");
  a_fail_cmp: assert property (!failOut_n && !$past(failInterruptMode) |-> $past(firstSpeedAlarmEvent || secondSpeedAlarmEvent))
    else $error("fail output without event");
  a_clear_rel: assert property ($fell(|fanFailStatus) && failInterruptMode |-> ##[0:2] failOut_n)
    else $error("fail output held after clear");
  a_load_first: assert property (!loadDone |-> alertOut_n && shutdownOut_n && failOut_n && !faultDutyActive)
    else $error("output active before load");
  cover property ($fell(alertOut_n));
  cover property ($fell(shutdownOut_n));
  cover property ($fell(failOut_n) && failInterruptMode);
endmodule
bind fac_alarm_regs fac_alarm_regs_monitor mon (.*);

/* testbench/test_fan_alarm_config_registers.sv */
// Self-checking bench for the fan alarm register bank over the two-wire bus.
`timescale 1ns/1ps
`include "fac_consts.svh"
module test_fan_alarm_config_registers;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic pwmLowestFreq = 1'b1;
  logic failInterruptMode = 1'b1;
  logic localHighAlarm = 1'b0;
  logic remoteOvertempAlarm = 1'b0;
  logic firstSpeedAlarmEvent = 1'b0;
  logic secondSpeedAlarmEvent = 1'b0;
  logic [15:0] localTemp = 16'h8000;
  logic [15:0] remoteTemp = 16'h8000;
  logic [7:0] nvData;
  logic sclIn, sdaIn, sdaOe, loadDone, stretchActive, faultDutyActive;
  logic firstSpeedMonitorEnable, secondSpeedMonitorEnable, alertOut_n, shutdownOut_n, failOut_n;
  logic [1:0] fanFailStatus;
  logic [7:0] nvAddr, faultDuty;
  logic [5:0] idealityCode;
  int errTotal = 0;
  int checksDone = 0;
  localparam logic [7:0] DEF [8] = '{8'h03, 8'hff, 8'hc0, 8'h18, 8'h55, 8'h00, 8'h55, 8'h00};
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // The store image holds the default of every register.
  always_comb begin
    nvData = 8'h00;
    if (nvAddr >= 8'h02 && nvAddr <= 8'h09) begin
      nvData = DEF[3'(nvAddr - 8'h02)];
    end
  end
  fac_alarm_regs DUT (
    .ref_clk, .sys_rst, .sclIn, .sdaIn, .sdaOut(), .sdaOe, .nvData, .nvAddr, .loadDone,
    .localTemp, .remoteTemp, .localHighAlarm, .remoteOvertempAlarm, .pwmLowestFreq,
    .failInterruptMode, .firstSpeedAlarmEvent, .secondSpeedAlarmEvent, .stretchActive,
    .firstSpeedMonitorEnable, .secondSpeedMonitorEnable, .fanFailStatus, .faultDutyActive,
    .faultDuty, .idealityCode, .alertOut_n, .shutdownOut_n, .failOut_n
  );
  fac_i2c_host host (.ref_clk, .sdaOe, .scl(sclIn), .sda(sdaIn));
  // ****************************************
  // Bus access and comparison tasks
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic sendAcked(input logic [7:0] b);
    logic [8:0] r;
    host.xferByte(b, 1'b1, r);
    check("ack", 16'(r[0]), 16'h0);
  endtask
  task automatic regWrite(input logic [7:0] ptr, input logic [7:0] val);
    host.start();
    sendAcked({`FAC_I2C_ADDR, 1'b0});
    sendAcked(ptr);
    sendAcked(val);
    host.stop();
  endtask
  task automatic readCheck(input logic [7:0] ptr, input logic [7:0] exp);
    logic [8:0] r;
    host.start();
    sendAcked({`FAC_I2C_ADDR, 1'b0});
    sendAcked(ptr);
    host.start();
    sendAcked({`FAC_I2C_ADDR, 1'b1});
    host.xferByte(8'hff, 1'b1, r);
    host.stop();
    check("register", 16'(r[8:1]), 16'(exp));
  endtask
  task automatic setCause(input int r, input logic on);
    case (r)
      0: localHighAlarm = on;
      1: localTemp = on ? 16'h5520 : 16'h5500;
      2: remoteTemp = on ? 16'h5600 : 16'h55e0;
      default: remoteOvertempAlarm = on;
    endcase
    step(3);
  endtask
  task automatic routeCheck(input int r, input logic exp);
    check("route", 16'(r[0] ? shutdownOut_n : alertOut_n), 16'(exp));
  endtask
  task automatic pulse(input logic [1:0] which);
    {secondSpeedAlarmEvent, firstSpeedAlarmEvent} = which;
    step(1);
    {secondSpeedAlarmEvent, firstSpeedAlarmEvent} = 2'b00;
    step(3);
  endtask
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    step(10);
    sys_rst = 1'b0;
    for (int i = 0; i < 40 && loadDone !== 1'b1; i++) step(1);
    step(2);
    check("loadDone", 16'(loadDone), 16'h1);
    check("faultDuty", 16'({faultDutyActive, faultDuty}), 16'h0ff);
    check("idealityCode", 16'(idealityCode), 16'h18);
    check("monitors", 16'({secondSpeedMonitorEnable, firstSpeedMonitorEnable}), 16'h3);
    check("stretch", 16'(stretchActive), 16'h0);
    for (int i = 0; i < 8; i++) readCheck(8'(i + 2), DEF[i]);
    regWrite(8'h07, 8'hff);
    readCheck(8'h07, 8'he0);
    regWrite(8'h0a, 8'h5a);
    readCheck(8'h0a, 8'h00);
    host.halfCyc = 12;
    regWrite(8'h05, 8'h2a);
    host.halfCyc = 6;
    check("idealityCode", 16'(idealityCode), 16'h2a);
    for (int r = 0; r < 4; r++) begin
      regWrite(8'h04, 8'hc0);
      setCause(r, 1'b0);
      routeCheck(r, 1'b1);
      setCause(r, 1'b1);
      routeCheck(r, 1'b0);
      regWrite(8'h04, 8'hc0 | (8'h20 >> r));
      routeCheck(r, 1'b1);
      setCause(r, 1'b0);
    end
    regWrite(8'h03, 8'h40);
    regWrite(8'h04, 8'hc0);
    pulse(2'b01);
    check("fail", 16'({fanFailStatus, failOut_n}), 16'h2);
    check("faultDuty", 16'({faultDutyActive, faultDuty}), 16'h140);
    regWrite(8'h02, 8'h83);
    check("clear", 16'({fanFailStatus, failOut_n}), 16'h1);
    readCheck(8'h02, 8'h03);
    regWrite(8'h04, 8'hc3);
    pulse(2'b11);
    check("masked", 16'({fanFailStatus, failOut_n}), 16'h7);
    regWrite(8'h04, 8'hc0);
    check("unmasked", 16'({fanFailStatus, failOut_n}), 16'h6);
    regWrite(8'h02, 8'h01);
    check("second off", 16'({secondSpeedMonitorEnable, fanFailStatus, failOut_n}), 16'h2);
    regWrite(8'h02, 8'h00);
    check("first off", 16'({firstSpeedMonitorEnable, fanFailStatus, failOut_n}), 16'h1);
    pulse(2'b11);
    check("both off", 16'(fanFailStatus), 16'h0);
    regWrite(8'h02, 8'h07);
    check("stretch", 16'(stretchActive), 16'h1);
    failInterruptMode = 1'b0;
    secondSpeedAlarmEvent = 1'b1;
    step(3);
    check("comparator", 16'(failOut_n), 16'h0);
    secondSpeedAlarmEvent = 1'b0;
    pwmLowestFreq = 1'b0;
    step(3);
    check("comparator", 16'(failOut_n), 16'h1);
    check("stretch", 16'(stretchActive), 16'h0);
    wrapUp();
  end
  initial begin
    step(60000);
    errTotal++;
    $display("watchdog expired");
    wrapUp();
  end
endmodule
